/* File: common/fcmp_pkg.sv */
// fcmp_pkg.sv: types for the floating-point comparator pipeline
// assumes: fcmp_regs.svh on the include path
`include "fcmp_regs.svh"
package fcmp_pkg;
	// relation flags travel together
	typedef struct packed {
		logic eq;
		logic ne;
		logic gt;
		logic ge;
		logic lt;
		logic le;
		logic unord;
	} fcmp_flags_s;
	// ordering class of a decoded operand
	typedef enum logic [2:0] {
		FCMP_CLS_ZERO = 3'h1,
		FCMP_CLS_NUM = 3'h2,
		FCMP_CLS_NAN = 3'h4
	} fcmp_cls_e;
endpackage

/* File: common/fcmp_regs.svh */
// fcmp_regs.svh: constants for the floating-point comparator pipeline
// assumes: included by bare name from the package file only
`ifndef FCMP_REGS_SVH
`define FCMP_REGS_SVH
`define FCMP_EXP_W_DEF 8
`define FCMP_MAN_W_DEF 23
`define FCMP_LAT_DEF 3
`define FCMP_LAT_MIN 1
`define FCMP_LAT_MAX 3
`define FCMP_EXP_W_DBL 11
`define FCMP_MAN_W_EXT_MIN 31
`define FCMP_SUM_W_LIMIT 64
`define FCMP_FIFO_DEPTH 8
`define FCMP_FLAG_W 7
`endif

/* File: dv/fcmp_pipe_tb_top.sv */
// fcmp_pipe_tb_top.sv: self-checking bench for the comparator pipeline
// assumes: default widths 8/23, latency 3, fifo depth 8
`timescale 1ns/100ps
`default_nettype none
module fcmp_pipe_tb_top import fcmp_pkg::*;;
	localparam int LAT = 3;
	logic mclk_in, rst_b_in, aclr_in, clk_en_in, res_ready_in, saw_stall;
	logic [31:0] opa_in, opb_in;
	logic [1:0] mode;
	fcmp_flags_s flags_out, res_flags_out, f;
	logic flags_valid_out, res_valid_out, stall_out;
	int num_checks, bad_count;
	fcmp_flags_s q[$];
	logic [63:0] vec [10] = '{64'h619BCE11_9106CA22, 64'h00600000_00700000,
		64'h00000000_80000000, 64'h7F800000_FF800000, 64'hFF800000_7F800000,
		64'h3F800000_40000000, 64'hC0000000_C0400000, 64'h7FC00000_3F800000,
		64'h3F800000_7F800001, 64'h3F800000_3F800000};
	fcmp_pipe #(.EXP_W(8), .MAN_W(23), .LAT(LAT), .DEPTH(8)) u_dut (.mclk_in(mclk_in),
		.rst_b_in(rst_b_in), .aclr_in(aclr_in), .clk_en_in(clk_en_in), .opa_in(opa_in),
		.opb_in(opb_in), .flags_out(flags_out), .flags_valid_out(flags_valid_out),
		.res_valid_out(res_valid_out), .res_ready_in(res_ready_in),
		.res_flags_out(res_flags_out), .stall_out(stall_out));
	fcmp_sink u_sink (.mclk_in(mclk_in), .mode_in(mode), .res_ready_out(res_ready_in));
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	function automatic fcmp_flags_s expf(input logic [31:0] a, input logic [31:0] b);
		logic na, nb, sa, sb, eq, gt;
		logic [30:0] ma, mb;
		expf = '0;
		// sign msb, then exponent, then mantissa
		na = (a[30:23] == 8'hFF) && (a[22:0] != 23'h0);
		nb = (b[30:23] == 8'hFF) && (b[22:0] != 23'h0);
		ma = (a[30:23] == 8'h00) ? 31'h0 : a[30:0];
		mb = (b[30:23] == 8'h00) ? 31'h0 : b[30:0];
		sa = a[31] && (ma != 31'h0);
		sb = b[31] && (mb != 31'h0);
		eq = (ma == mb) && (sa == sb);
		gt = !eq && ((sa != sb) ? sb : (sa ? (ma < mb) : (ma > mb)));
		if (na || nb) begin
			expf.ne = 1'b1;
			expf.unord = 1'b1;
		end else begin
			expf.eq = eq;
			expf.ne = !eq;
			expf.gt = gt;
			expf.ge = gt || eq;
			expf.lt = !gt && !eq;
			expf.le = !gt;
		end
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ops held until an edge with the fifo not full
	task automatic send(input logic [31:0] a, input logic [31:0] b);
		int n;
		opa_in = a;
		opb_in = b;
		clk_en_in = 1'b1;
		q.push_back(expf(a, b));
		n = 0;
		#1;
		while (stall_out !== 1'b0 && n < 50) begin
			saw_stall = 1'b1;
			if (n == 6) mode = 2'h1;
			@(negedge mclk_in);
			#1;
			n++;
		end
		if (n == 50) begin
			chk(32'h0, 32'h1);
			test_done();
		end
		@(negedge mclk_in);
	endtask
	task automatic drain;
		int n;
		clk_en_in = 1'b0;
		n = 0;
		while (res_valid_out !== 1'b0 && n < 100) begin
			@(negedge mclk_in);
			n++;
		end
		if (n == 100) begin
			chk(32'h0, 32'h2);
			test_done();
		end
	endtask
	// every popped entry must match the oldest outstanding result
	always @(posedge mclk_in) begin
		if (rst_b_in && !aclr_in && res_valid_out === 1'b1 && res_ready_in) begin
			if (q.size() == 0) chk({25'h0, res_flags_out}, 32'hFF);
			else chk({25'h0, res_flags_out}, {25'h0, q.pop_front()});
		end
	end
	initial begin
		rst_b_in = 1'b1;
		aclr_in = 1'b0;
		clk_en_in = 1'b0;
		opa_in = 32'h0;
		opb_in = 32'h0;
		mode = 2'h0;
		saw_stall = 1'b0;
		num_checks = 0;
		bad_count = 0;
		// falls after time zero so the async reset surely sees the edge
		#1;
		rst_b_in = 1'b0;
		repeat (3) @(negedge mclk_in);
		rst_b_in = 1'b1;
		foreach (vec[i]) begin
			send(vec[i][63:32], vec[i][31:0]);
			if (i >= LAT - 1) chk({25'h0, flags_out}, {25'h0, expf(vec[i-LAT+1][63:32],
				vec[i-LAT+1][31:0])});
		end
		f = flags_out;
		clk_en_in = 1'b0;
		opa_in = 32'hBF800000;
		repeat (4) begin
			@(negedge mclk_in);
			chk({25'h0, flags_out}, {25'h0, f});
		end
		drain();
		aclr_in = 1'b1;
		#1;
		chk({31'h0, flags_valid_out}, 32'h0);
		@(negedge mclk_in);
		aclr_in = 1'b0;
		q.delete();
		for (int i = 0; i < LAT; i++) begin
			send(32'h3FC00000, 32'h3F800000);
			chk({31'h0, flags_valid_out}, 32'(i == LAT - 1));
		end
		mode = 2'h2;
		for (int i = 0; i < 14; i++) send(vec[i%10][63:32], vec[i%10][31:0]);
		chk({31'h0, saw_stall}, 32'h1);
		drain();
		chk(32'(q.size()), 32'(LAT));
		test_done();
	end
	initial begin
		#400000;
		chk(32'h0, 32'h3);
		test_done();
	end
endmodule
`default_nettype wire

/* File: dv/fcmp_sink.sv */
// fcmp_sink.sv: consumer of the buffered flag stream
// assumes: mclk_in domain; ready changes at the falling edge
`timescale 1ns/100ps
`default_nettype none
module fcmp_sink (
	// clock
	input wire logic mclk_in,
	// pacing: 0 prompt, 1 every other cycle, 2 stalled
	input wire logic [1:0] mode_in,
	// stream handshake
	output logic res_ready_out
);
	logic tog_q;
	initial begin
		tog_q = 1'b0;
		res_ready_out = 1'b0;
	end
	// only popped entries are used, never raw start-up flags
	always @(negedge mclk_in) begin
		tog_q <= ~tog_q;
		res_ready_out <= (mode_in == 2'h0) || (mode_in == 2'h1 && tog_q);
	end
endmodule
`default_nettype wire

/* File: rtl/fcmp_fifo.sv */
// fcmp_fifo.sv: synchronous fifo with valid/ready on both sides
// assumes: one clock, active-low async reset, clear is synchronous
`timescale 1ns/100ps
`default_nettype none
module fcmp_fifo #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic clr_in,
	// fill side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// drain side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready_out = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) && !clr_in;
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (clr_in) begin
			wr_d = '0;
			rd_d = '0;
			cnt_d = '0;
		end else begin
			if (push) begin
				wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage carries no reset
	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	a_fifo_no_overrun: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
		cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

/* File: rtl/fcmp_pipe.sv */
// fcmp_pipe.sv: pipelined floating-point comparator, flags after LAT cycles
// assumes: operands from logic on mclk_in; the user enable and clear come
// from the same clock domain; a fifo of results feeds the consumer
`timescale 1ns/100ps
`default_nettype none
module fcmp_pipe import fcmp_pkg::*; #(
	parameter int EXP_W = `FCMP_EXP_W_DEF,
	parameter int MAN_W = `FCMP_MAN_W_DEF,
	parameter int LAT = `FCMP_LAT_DEF,
	parameter int DEPTH = `FCMP_FIFO_DEPTH
) (
	// clock and resets
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic aclr_in,
	input wire logic clk_en_in,
	// operands
	input wire logic [EXP_W+MAN_W:0] opa_in,
	input wire logic [EXP_W+MAN_W:0] opb_in,
	// flags direct from the pipeline
	output fcmp_flags_s flags_out,
	output logic flags_valid_out,
	// buffered flags stream
	output logic res_valid_out,
	input wire logic res_ready_in,
	output fcmp_flags_s res_flags_out,
	output logic stall_out
);
	localparam int W = EXP_W + MAN_W + 1;
	localparam logic [EXP_W-1:0] BIAS = EXP_W'((1 << (EXP_W - 1)) - 1);
	localparam logic [EXP_W-1:0] EXP_ALL1 = '1;

	// elaboration checks on the widths and latency
	initial begin
		if (LAT < `FCMP_LAT_MIN || LAT > `FCMP_LAT_MAX) begin
			$error("latency must be 1, 2 or 3");
		end
		if (EXP_W >= MAN_W || EXP_W + MAN_W >= `FCMP_SUM_W_LIMIT) begin
			$error("exponent width out of range");
		end
		if (!(EXP_W == `FCMP_EXP_W_DEF && MAN_W == `FCMP_MAN_W_DEF) &&
			MAN_W < `FCMP_MAN_W_EXT_MIN) begin
			$error("mantissa width out of range");
		end
	end

	// async clear merged with system reset
	logic arst_b;
	assign arst_b = rst_b_in && !aclr_in;

	// operand fields, sign at the top
	logic sa, sb;
	logic [EXP_W-1:0] ea, eb;
	logic [MAN_W-1:0] ma, mb;
	assign sa = opa_in[W-1];
	assign sb = opb_in[W-1];
	assign ea = opa_in[W-2:MAN_W];
	assign eb = opb_in[W-2:MAN_W];
	assign ma = opa_in[MAN_W-1:0];
	assign mb = opb_in[MAN_W-1:0];

	function automatic fcmp_cls_e classify(input logic [EXP_W-1:0] e,
		input logic [MAN_W-1:0] m);
		fcmp_cls_e c;
		c = FCMP_CLS_NUM;
		if (e == '0) begin
			c = FCMP_CLS_ZERO;
		end else if (e == EXP_ALL1 && m != '0) begin
			c = FCMP_CLS_NAN;
		end
		return c;
	endfunction

	fcmp_cls_e ca, cb;
	assign ca = classify(ea, ma);
	assign cb = classify(eb, mb);

	// combinational compare of the input pair, straight from opa_in and opb_in
	fcmp_flags_s raw;
	logic [W-2:0] mag_a, mag_b;
	logic a_neg, b_neg, mag_gt, mag_eq, agt, aeq;
	always_comb begin
		raw = '0;
		// flushed denormals and signed zeros collapse to plain zero
		mag_a = (ca == FCMP_CLS_ZERO) ? '0 : opa_in[W-2:0];
		mag_b = (cb == FCMP_CLS_ZERO) ? '0 : opb_in[W-2:0];
		a_neg = sa && (mag_a != '0);
		b_neg = sb && (mag_b != '0);
		mag_gt = mag_a > mag_b;
		mag_eq = mag_a == mag_b;
		aeq = mag_eq && (a_neg == b_neg);
		// infinities sit at the magnitude top, so the magnitude compare covers them
		if (a_neg != b_neg) begin
			agt = b_neg;
		end else if (a_neg) begin
			agt = !mag_gt && !mag_eq;
		end else begin
			agt = mag_gt;
		end
		if (ca == FCMP_CLS_NAN || cb == FCMP_CLS_NAN) begin
			raw.unord = 1'b1;
			raw.ne = 1'b1;
		end else begin
			raw.eq = aeq;
			raw.gt = agt;
			raw.ge = agt || aeq;
			raw.lt = !agt && !aeq;
			raw.le = !agt;
			raw.ne = !aeq;
		end
	end

	// delay line, depth LAT, with valid tag
	fcmp_flags_s stg_q [LAT];
	fcmp_flags_s stg_d [LAT];
	logic [LAT-1:0] vld_q, vld_d;
	logic fifo_ready, adv;
	assign adv = clk_en_in && fifo_ready;
	assign stall_out = clk_en_in && !fifo_ready;

	genvar gi;
	generate
		for (gi = 0; gi < LAT; gi++) begin : g_stage
			always_comb begin
				stg_d[gi] = stg_q[gi];
				vld_d[gi] = vld_q[gi];
				if (adv) begin
					stg_d[gi] = (gi == 0) ? raw : stg_q[(gi == 0) ? 0 : gi-1];
					vld_d[gi] = (gi == 0) ? 1'b1 : vld_q[(gi == 0) ? 0 : gi-1];
				end
			end
			always_ff @(posedge mclk_in or negedge arst_b) begin
				if (!arst_b) begin
					stg_q[gi] <= '0;
					vld_q[gi] <= 1'b0;
				end else begin
					stg_q[gi] <= stg_d[gi];
					vld_q[gi] <= vld_d[gi];
				end
			end
		end
	endgenerate

	assign flags_out = stg_q[LAT-1];
	// marks the end of start-up after clear
	assign flags_valid_out = vld_q[LAT-1];

	// push each result once, on the advance that moves it out of the pipe end
	logic push;
	assign push = adv && vld_q[LAT-1];

	fcmp_fifo #(
		.WIDTH(`FCMP_FLAG_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.clr_in(aclr_in),
		.in_valid_in(push),
		.in_ready_out(fifo_ready),
		.in_data_in(flags_out),
		.out_valid_out(res_valid_out),
		.out_ready_in(res_ready_in),
		.out_data_out(res_flags_out)
	);

	// checks
	// helper: run of back-to-back advancing edges, saturating at LAT
	localparam int CW = $clog2(LAT + 1);
	logic [CW-1:0] adv_run_q, adv_run_d;
	always_comb begin
		adv_run_d = '0;
		if (adv) begin
			adv_run_d = (adv_run_q == CW'(LAT)) ? adv_run_q : adv_run_q + CW'(1);
		end
	end
	always_ff @(posedge mclk_in or negedge arst_b) begin
		if (!arst_b) begin
			adv_run_q <= '0;
		end else begin
			adv_run_q <= adv_run_d;
		end
	end

	// helper: order keys, a plain unsigned compare of them is float order
	logic [W-1:0] key_a, key_b;
	always_comb begin
		key_a = {1'b1, mag_a};
		key_b = {1'b1, mag_b};
		if (a_neg) begin
			key_a = {1'b0, ~mag_a};
		end
		if (b_neg) begin
			key_b = {1'b0, ~mag_b};
		end
	end

	// pipeline timing
	a_lat_exact: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(adv_run_q == CW'(LAT)) |-> flags_out == $past(raw, LAT))
		else $error("flags not at configured latency");
	a_stage_cap: assert property (@(posedge mclk_in) disable iff (!arst_b)
		adv |=> stg_q[0] == $past(raw))
		else $error("pair not captured on advance");
	for (gi = 1; gi < LAT; gi++) begin : g_stage_chk
		a_stage_move: assert property (@(posedge mclk_in) disable iff (!arst_b)
			adv |=> stg_q[gi] == $past(stg_q[gi-1]))
			else $error("stage word did not move on");
	end
	a_hold_idle: assert property (@(posedge mclk_in) disable iff (!arst_b)
		!adv |=> $stable(flags_out) && $stable(flags_valid_out))
		else $error("flags moved while disabled");
	a_cap_hold: assert property (@(posedge mclk_in) disable iff (!arst_b)
		!adv |=> stg_q[0] == $past(stg_q[0]))
		else $error("first stage moved while held");
	a_stall_hold: assert property (@(posedge mclk_in) disable iff (!arst_b)
		stall_out |=> $stable(flags_out))
		else $error("flags moved during stall");
	a_clear_zero: assert property (@(posedge mclk_in)
		!arst_b |-> flags_valid_out == 1'b0 && flags_out == '0)
		else $error("clear did not empty pipe");
	a_wake_lat: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(adv_run_q == CW'(LAT)) |-> flags_valid_out)
		else $error("no result after clear release");
	a_valid_keep: assert property (@(posedge mclk_in) disable iff (!arst_b)
		flags_valid_out |=> flags_valid_out)
		else $error("result valid dropped");
	a_idle_zero: assert property (@(posedge mclk_in) disable iff (!arst_b)
		!flags_valid_out |-> flags_out == '0)
		else $error("start-up flags not zero");

	// flags of the current pair
	a_eq_ne: assert property (@(posedge mclk_in) disable iff (!arst_b)
		raw.eq != raw.ne || raw.unord)
		else $error("equal and not-equal clash");
	a_ne_join: assert property (@(posedge mclk_in) disable iff (!arst_b)
		raw.ne == !raw.eq)
		else $error("not-equal is not the inverse of equal");
	a_gt_lt: assert property (@(posedge mclk_in) disable iff (!arst_b)
		!raw.unord |-> (raw.gt + raw.lt + raw.eq) == 2'h1)
		else $error("order flags not exclusive");
	a_ge_join: assert property (@(posedge mclk_in) disable iff (!arst_b)
		raw.ge == (raw.gt || raw.eq) && raw.le == (raw.lt || raw.eq))
		else $error("ge or le mismatch");
	a_ge_le_eq: assert property (@(posedge mclk_in) disable iff (!arst_b)
		raw.ge && raw.le |-> raw.eq)
		else $error("ge and le without equal");
	a_lt_order: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_NUM && cb == FCMP_CLS_NUM && sa && !sb) |-> raw.lt)
		else $error("negative not below positive");
	a_neg_order: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_NUM && cb == FCMP_CLS_NUM && sa && sb && mag_a < mag_b) |-> raw.gt)
		else $error("negative order wrong");
	a_pos_order: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_NUM && cb == FCMP_CLS_NUM && !sa && !sb && mag_a < mag_b)
		|-> raw.lt && raw.le && !raw.ge) else $error("positive order wrong");
	a_le_zero: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_ZERO && cb == FCMP_CLS_ZERO) |-> raw.le && raw.eq)
		else $error("zeros not equal");
	a_denorm_eq: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_ZERO && cb == FCMP_CLS_ZERO && opa_in != opb_in) |-> raw.eq)
		else $error("flushed operands not equal");
	a_zero_sign: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_ZERO && cb == FCMP_CLS_ZERO && sa != sb) |-> raw.eq)
		else $error("signed zeros not equal");
	a_nan_flags: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_NAN) |-> raw.unord && raw.ne && !raw.ge && !raw.le)
		else $error("nan flags wrong");
	a_nan_b: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(cb == FCMP_CLS_NAN) |-> raw.unord && raw.ne && !raw.eq && !raw.gt && !raw.lt)
		else $error("nan on b flags wrong");
	a_nan_excl: assert property (@(posedge mclk_in) disable iff (!arst_b)
		raw.unord |-> !raw.ge && !raw.le && !raw.lt && !raw.gt && !raw.eq)
		else $error("unordered with order flag");
	a_ne_diff: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ca == FCMP_CLS_NUM && opa_in != opb_in && cb == FCMP_CLS_NUM) |-> raw.ne)
		else $error("distinct numbers not unequal");
	a_bias_const: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ea == BIAS && eb == BIAS && !sa && !sb && ma > mb) |-> raw.gt)
		else $error("same-exponent order wrong");
	a_inf_sign: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ea == EXP_ALL1 && ma == '0 && sa && eb == EXP_ALL1 && mb == '0 && !sb)
		|-> raw.lt) else $error("infinities misordered");
	a_inf_pos: assert property (@(posedge mclk_in) disable iff (!arst_b)
		(ea == EXP_ALL1 && ma == '0 && !sa && eb == EXP_ALL1 && mb == '0 && sb)
		|-> raw.gt) else $error("positive infinity not above");

	// against the order keys
	a_key_eq: assert property (@(posedge mclk_in) disable iff (!arst_b)
		!raw.unord |-> raw.eq == (key_a == key_b))
		else $error("equal flag disagrees with keys");
	a_key_gt: assert property (@(posedge mclk_in) disable iff (!arst_b)
		!raw.unord |-> raw.gt == (key_a > key_b))
		else $error("greater flag disagrees with keys");
	a_key_lt: assert property (@(posedge mclk_in) disable iff (!arst_b)
		!raw.unord |-> raw.lt == (key_a < key_b))
		else $error("less flag disagrees with keys");

	// flags at the pipe end
	a_unord_ne: assert property (@(posedge mclk_in) disable iff (!arst_b)
		flags_out.unord |-> flags_out.ne && !flags_out.eq && !flags_out.gt)
		else $error("unordered leaves order flags");
	a_out_excl: assert property (@(posedge mclk_in) disable iff (!arst_b)
		flags_valid_out && !flags_out.unord
		|-> (flags_out.gt + flags_out.lt + flags_out.eq) == 2'h1)
		else $error("output order flags not exclusive");
	a_out_ge_le: assert property (@(posedge mclk_in) disable iff (!arst_b)
		flags_out.ge == (flags_out.gt || flags_out.eq)
		&& flags_out.le == (flags_out.lt || flags_out.eq))
		else $error("output ge or le mismatch");
	a_out_ne: assert property (@(posedge mclk_in) disable iff (!arst_b)
		flags_valid_out |-> flags_out.ne == !flags_out.eq)
		else $error("output not-equal wrong");

	c_equal: cover property (@(posedge mclk_in) disable iff (!arst_b) flags_out.eq);
	c_nan: cover property (@(posedge mclk_in) disable iff (!arst_b) flags_out.unord);
	c_stall: cover property (@(posedge mclk_in) disable iff (!arst_b) stall_out);
	c_denorm: cover property (@(posedge mclk_in) disable iff (!arst_b)
		ea == '0 && ma != '0 && eb == '0 && mb != '0 && ma != mb);
	c_wake: cover property (@(posedge mclk_in) disable iff (!arst_b)
		adv_run_q == CW'(LAT) && flags_valid_out);
endmodule
`default_nettype wire
